// ### core/bool_exec_pkg.sv
// constants, operation codes and carrier types for the boolean and bit-branch unit
package bool_exec_pkg;

    // instruction word layout, 24-bit formats only
    localparam int WORD_W = 24;
    localparam int F_OP0_LSB = 0;
    localparam int F_T_LSB = 4;
    localparam int F_S_LSB = 8;
    localparam int F_R_LSB = 12;
    localparam int F_OP1_LSB = 16;
    localparam int F_OP2_LSB = 20;
    localparam int F_OFF_LSB = 16;

    // fixed opcode field values
    localparam logic [3:0] OP0_RRR = 4'h0;
    localparam logic [3:0] OP0_BRANCH = 4'h7;
    localparam logic [3:0] OP1_LOGIC = 4'h0;
    localparam logic [3:0] OP1_PRED2 = 4'h2;
    localparam logic [3:0] OP2_REDUCE = 4'h0;
    localparam logic [3:0] OP2_AND = 4'h1;
    localparam logic [3:0] OP2_PAND = 4'h0;
    localparam logic [3:0] OP2_PANDN = 4'h1;
    localparam logic [3:0] R_ANY_OF_FOUR = 4'h8;
    localparam logic [3:0] R_ALL_OF_FOUR = 4'h9;
    localparam logic [3:0] R_ANY_OF_EIGHT = 4'hA;
    localparam logic [3:0] R_ALL_OF_EIGHT = 4'hB;
    localparam logic [3:0] R_BRANCH_ALL_SET = 4'h4;
    localparam logic [3:0] R_BBC = 4'h5;
    localparam logic [3:0] R_BRANCH_ANY_SET = 4'h8;

    // program counter arithmetic
    localparam logic [31:0] INSN_BYTES = 32'h0000_0003;
    localparam logic [31:0] BRANCH_BIAS = 32'h0000_0004;

    // reset values; nothing outside this unit writes the predicate file,
    // so it wakes in a mixed pattern that the reductions can work on
    localparam logic [15:0] PRED_RESET = 16'hFFC2;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ALL_OF_FOUR = 4'h1,
        OP_ALL_OF_EIGHT = 4'h2,
        OP_ANY_OF_FOUR = 4'h3,
        OP_ANY_OF_EIGHT = 4'h4,
        OP_GAND = 4'h5,
        OP_PAND = 4'h6,
        OP_PANDN = 4'h7,
        OP_BRANCH_ALL_SET = 4'h8,
        OP_BRANCH_ANY_SET = 4'h9,
        OP_BBC = 4'hA
    } op_t;

    // one instruction offered by fetch, with its register operands
    typedef struct packed {
        logic valid;
        logic [23:0] word;
        logic [31:0] pc;
        logic [31:0] s_val;
        logic [31:0] t_val;
    } issue_t;

    // decoded fields
    typedef struct packed {
        op_t op;
        logic [3:0] r;
        logic [3:0] s;
        logic [3:0] t;
        logic [7:0] off;
    } decode_t;

    // result handed to writeback and fetch
    typedef struct packed {
        logic done;
        logic illegal;
        logic gr_we;
        logic [3:0] gr_idx;
        logic [31:0] gr_data;
        logic br_valid;
        logic br_taken;
        logic [31:0] next_pc;
    } result_t;

endpackage

// ### core/bool_logic_bit_branch_exec.sv
// decode and execute of boolean reductions, mask branches and bit-clear branch
`timescale 1ns/100ps
`default_nettype none

module bool_logic_bit_branch_exec
    import bool_exec_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic pred_feature_en,
    input wire logic big_endian_flag,
    input wire issue_t issue,
    output logic [15:0] pred_bits,
    output result_t result
);

    logic [15:0] pred_reg;
    logic [15:0] pred_next;
    result_t res_reg;
    result_t res_next;
    decode_t dec;
    logic is_pred_op;
    logic [3:0] base4;
    logic [3:0] base8;
    logic [4:0] bit_sel;
    logic [31:0] off_ext;
    logic cond;

    // field split and opcode match; only 24-bit words reach this unit
    always_comb begin
        dec.r = issue.word[F_R_LSB +: 4];
        dec.s = issue.word[F_S_LSB +: 4];
        dec.t = issue.word[F_T_LSB +: 4];
        dec.off = issue.word[F_OFF_LSB +: 8];
        dec.op = OP_NONE;
        if (issue.word[F_OP0_LSB +: 4] == OP0_RRR) begin
            unique case (issue.word[F_OP1_LSB +: 4])
                OP1_LOGIC: begin
                    if (issue.word[F_OP2_LSB +: 4] == OP2_AND) begin
                        dec.op = OP_GAND;
                    end else if (issue.word[F_OP2_LSB +: 4] == OP2_REDUCE) begin
                        unique case (dec.r)
                            R_ALL_OF_FOUR: dec.op = OP_ALL_OF_FOUR;
                            R_ALL_OF_EIGHT: dec.op = OP_ALL_OF_EIGHT;
                            R_ANY_OF_FOUR: dec.op = OP_ANY_OF_FOUR;
                            R_ANY_OF_EIGHT: dec.op = OP_ANY_OF_EIGHT;
                            default: dec.op = OP_NONE;
                        endcase
                    end
                end
                OP1_PRED2: begin
                    if (issue.word[F_OP2_LSB +: 4] == OP2_PAND) begin
                        dec.op = OP_PAND;
                    end else if (issue.word[F_OP2_LSB +: 4] == OP2_PANDN) begin
                        dec.op = OP_PANDN;
                    end
                end
                default: dec.op = OP_NONE;
            endcase
        end else if (issue.word[F_OP0_LSB +: 4] == OP0_BRANCH) begin
            unique case (dec.r)
                R_BRANCH_ALL_SET: dec.op = OP_BRANCH_ALL_SET;
                R_BRANCH_ANY_SET: dec.op = OP_BRANCH_ANY_SET;
                R_BBC: dec.op = OP_BBC;
                default: dec.op = OP_NONE;
            endcase
        end
    end

    // predicate group, gated by the configured feature
    assign is_pred_op = (dec.op == OP_ALL_OF_FOUR) || (dec.op == OP_ALL_OF_EIGHT) ||
                        (dec.op == OP_ANY_OF_FOUR) || (dec.op == OP_ANY_OF_EIGHT) ||
                        (dec.op == OP_PAND) || (dec.op == OP_PANDN);

    // misaligned bases are forced aligned; software must not rely on it
    assign base4 = {dec.s[3:2], 2'b00};
    assign base8 = {dec.s[3], 3'b000};

    // endian-aware bit index and sign-extended offset
    assign bit_sel = issue.t_val[4:0] ^ {5{big_endian_flag}};
    assign off_ext = {{24{dec.off[7]}}, dec.off};

    // branch conditions
    always_comb begin
        cond = 1'b0;
        unique case (dec.op)
            OP_BRANCH_ALL_SET: cond = ((~issue.s_val & issue.t_val) == 32'h0000_0000);
            OP_BRANCH_ANY_SET: cond = ((issue.s_val & issue.t_val) != 32'h0000_0000);
            OP_BBC: cond = ~issue.s_val[bit_sel];
            default: cond = 1'b0;
        endcase
    end

    // next values for predicate file and result
    always_comb begin
        pred_next = pred_reg;
        res_next = '0;
        res_next.next_pc = res_reg.next_pc;
        if (issue.valid) begin
            res_next.done = 1'b1;
            if (dec.op == OP_NONE || (is_pred_op && !pred_feature_en)) begin
                res_next.illegal = 1'b1;
            end else begin
                unique case (dec.op)
                    OP_ALL_OF_FOUR: pred_next[dec.t] = &pred_reg[base4 +: 4];
                    OP_ALL_OF_EIGHT: pred_next[dec.t] = &pred_reg[base8 +: 8];
                    OP_ANY_OF_FOUR: pred_next[dec.t] = |pred_reg[base4 +: 4];
                    OP_ANY_OF_EIGHT: pred_next[dec.t] = |pred_reg[base8 +: 8];
                    OP_PAND: pred_next[dec.r] = pred_reg[dec.s] & pred_reg[dec.t];
                    OP_PANDN: pred_next[dec.r] = pred_reg[dec.s] & ~pred_reg[dec.t];
                    OP_GAND: begin
                        res_next.gr_we = 1'b1;
                        res_next.gr_idx = dec.r;
                        res_next.gr_data = issue.s_val & issue.t_val;
                    end
                    default: begin
                        res_next.br_valid = 1'b1;
                        res_next.br_taken = cond;
                    end
                endcase
            end
            // every accepted word except a taken branch advances the pc by one 24-bit instruction
            if (res_next.br_valid && cond) begin
                res_next.next_pc = issue.pc + off_ext + BRANCH_BIAS;
            end else begin
                res_next.next_pc = issue.pc + INSN_BYTES;
            end
        end
    end

    // registered state; sixteen one-bit predicate entries
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pred_reg <= PRED_RESET;
            res_reg <= '0;
        end else begin
            pred_reg <= pred_next;
            res_reg <= res_next;
        end
    end

    assign pred_bits = pred_reg;
    assign result = res_reg;

    // snapshot of the previous issue, read only by the checks below
    issue_t prev_issue;
    decode_t prev_dec;
    logic [15:0] prev_pred;
    logic prev_feat;
    logic prev_be;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_issue <= '0;
            prev_dec <= '0;
            prev_pred <= PRED_RESET;
            prev_feat <= 1'b0;
            prev_be <= 1'b0;
        end else begin
            prev_issue <= issue;
            prev_dec <= dec;
            prev_pred <= pred_reg;
            prev_feat <= pred_feature_en;
            prev_be <= big_endian_flag;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // steps of an operation: accepted one cycle, result the next
    sequence s_issue(op_t o);
        issue.valid && dec.op == o && pred_feature_en;
    endsequence

    sequence s_branch_issue;
        issue.valid && (dec.op == OP_BRANCH_ALL_SET || dec.op == OP_BRANCH_ANY_SET ||
                        dec.op == OP_BBC);
    endsequence

    AST_ALL_OF_FOUR: assert property (
        s_issue(OP_ALL_OF_FOUR) ##1 1'b1 |->
        pred_reg[prev_dec.t] == (prev_pred[{prev_dec.s[3:2], 2'b00}] &
            prev_pred[{prev_dec.s[3:2], 2'b01}] &
            prev_pred[{prev_dec.s[3:2], 2'b10}] &
            prev_pred[{prev_dec.s[3:2], 2'b11}]))
        else $error("all_of_four result wrong");

    AST_ALL_OF_EIGHT: assert property (
        s_issue(OP_ALL_OF_EIGHT) |=>
        pred_reg[prev_dec.t] == (prev_pred[{prev_dec.s[3], 3'b000} +: 8]
            == 8'hFF))
        else $error("all_of_eight result wrong");

    AST_ANY_OF_FOUR: assert property (
        s_issue(OP_ANY_OF_FOUR) |=>
        pred_reg[prev_dec.t] == (prev_pred[{prev_dec.s[3:2], 2'b00} +: 4]
            != 4'h0))
        else $error("any_of_four result wrong");

    AST_ANY_OF_EIGHT: assert property (
        s_issue(OP_ANY_OF_EIGHT) |=>
        pred_reg[prev_dec.t] == (prev_pred[{prev_dec.s[3], 3'b000} +: 8]
            != 8'h00))
        else $error("any_of_eight result wrong");

    AST_GAND: assert property (
        issue.valid && dec.op == OP_GAND |=>
        result.gr_we && result.gr_idx == prev_dec.r &&
        result.gr_data == (prev_issue.s_val & prev_issue.t_val))
        else $error("general register and wrong");

    AST_PAND: assert property (
        s_issue(OP_PAND) |=>
        pred_reg[prev_dec.r] == (prev_pred[prev_dec.s] &
            prev_pred[prev_dec.t]))
        else $error("predicate_and wrong");

    AST_PANDN: assert property (
        s_issue(OP_PANDN) |=>
        pred_reg[prev_dec.r] == (prev_pred[prev_dec.s] &
            !prev_pred[prev_dec.t]))
        else $error("predicate_and_not wrong");

    AST_BRANCH_ALL_SET: assert property (
        issue.valid && dec.op == OP_BRANCH_ALL_SET |=>
        result.br_valid && result.br_taken ==
            ((~prev_issue.s_val & prev_issue.t_val) == 32'h0000_0000))
        else $error("branch_all_set condition wrong");

    AST_BRANCH_ANY_SET: assert property (
        issue.valid && dec.op == OP_BRANCH_ANY_SET |=>
        result.br_taken == ((prev_issue.s_val & prev_issue.t_val) != 0))
        else $error("branch_any_set condition wrong");

    AST_TARGET: assert property (
        s_branch_issue ##1 result.br_taken |->
        result.next_pc == $past(issue.pc) +
            {{24{prev_dec.off[7]}}, prev_dec.off} + 32'h0000_0004)
        else $error("taken target wrong");

    AST_FALLTHRU: assert property (
        issue.valid ##1 !result.br_taken |->
        result.next_pc == prev_issue.pc + 32'h0000_0003)
        else $error("sequential pc wrong");

    AST_BBC: assert property (
        issue.valid && dec.op == OP_BBC |=>
        result.br_taken == !prev_issue.s_val[prev_be ?
            5'd31 - prev_issue.t_val[4:0] : prev_issue.t_val[4:0]])
        else $error("branch_bit_clear condition wrong");

    AST_NOFEAT: assert property (
        issue.valid && is_pred_op && !pred_feature_en |=>
        result.illegal && pred_reg == prev_pred)
        else $error("predicate op ran without feature");

    AST_IDLE: assert property (
        !issue.valid |=> !result.done && pred_reg == $past(pred_reg))
        else $error("state changed while idle");

    // gate follows the feature input sampled with the word
    AST_FEAT_OK: assert property (
        issue.valid && is_pred_op |=>
        result.done && result.illegal == !prev_feat)
        else $error("predicate op gating wrong");

    // refused words leave the predicate file, register write and branch outputs alone
    AST_UNKNOWN: assert property (
        issue.valid && dec.op == OP_NONE |=>
        result.illegal && !result.gr_we && !result.br_valid &&
        pred_reg == prev_pred)
        else $error("unknown word changed state");

    AST_NO_GR_WE: assert property (
        issue.valid && dec.op != OP_GAND |=> !result.gr_we)
        else $error("register write without bitwise and");

    AST_NOBRANCH: assert property (
        issue.valid && !(dec.op inside {OP_BRANCH_ALL_SET, OP_BRANCH_ANY_SET, OP_BBC}) |=>
        !result.br_valid && !result.br_taken)
        else $error("branch reported for non-branch word");

endmodule

`default_nettype wire

// ### testbench/fetch_regfile_model.sv
// fetch stage and general register file model facing the exec unit
`timescale 1ns/100ps
`default_nettype none
module fetch_regfile_model
    import bool_exec_pkg::*;
(
    input wire logic mclk,
    input wire result_t result,
    output var issue_t issue
);
    logic [31:0] regs [16];

    // one 24-bit word per call, operands read from regs
    task automatic offer(input logic [23:0] w, input logic [31:0] pc);
        @(negedge mclk);
        issue.valid = 1'b1;
        issue.word = w;
        issue.pc = pc;
        issue.s_val = regs[w[11:8]];
        issue.t_val = regs[w[7:4]];
        @(negedge mclk);
        issue.valid = 1'b0;
        // released lines show the inverse so stale values cannot pass
        issue.s_val = ~issue.s_val;
        issue.t_val = ~issue.t_val;
        issue.word = ~issue.word;
    endtask

    // general register writeback from the exec result
    always @(posedge mclk) begin
        if (result.gr_we === 1'b1) begin
            regs[result.gr_idx] <= result.gr_data;
        end
    end

    // callers only use aligned reduction sources
    initial begin
        issue = '0;
        for (int i = 0; i < 16; i++) begin
            regs[i] = 32'h0;
        end
    end
endmodule
`default_nettype wire

// ### testbench/bool_logic_bit_branch_exec_test.sv
// self-checking bench for the boolean and bit-branch exec unit
`timescale 1ns/100ps
`default_nettype none
module bool_logic_bit_branch_exec_test
    import bool_exec_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic pred_feature_en = 1'b1;
    logic big_endian_flag = 1'b0;
    issue_t issue;
    logic [15:0] pred_bits;
    result_t result;
    int err_total = 0;
    int comparisons = 0;

    // 50 MHz core clock
    always #10 mclk = ~mclk;

    bool_logic_bit_branch_exec bool_logic_bit_branch_exec_inst (
        .mclk(mclk), .rst(rst), .pred_feature_en(pred_feature_en),
        .big_endian_flag(big_endian_flag), .issue(issue),
        .pred_bits(pred_bits), .result(result));

    fetch_regfile_model fetch_regfile_model_inst (
        .mclk(mclk), .result(result), .issue(issue));

    task automatic check_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            $display("Error %s expected %0b seen %0b", n, e, g);
            err_total++;
        end
    endtask

    task automatic check_word(input string n, input logic [31:0] e,
                              input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // bitwise and of two general registers
    task automatic test_gand();
        fetch_regfile_model_inst.regs[2] = 32'hF0F0_1234;
        fetch_regfile_model_inst.regs[3] = 32'h0FF0_FF00;
        fetch_regfile_model_inst.offer(24'h105230, 32'h0000_0100);
        check_bit("done", 1'b1, result.done);
        check_bit("gr_we", 1'b1, result.gr_we);
        check_word("gr_idx", 32'h5, {28'h0, result.gr_idx});
        check_word("gr_data", 32'h00F0_1200, result.gr_data);
        check_word("next_pc", 32'h0000_0103, result.next_pc);
        check_bit("br_valid", 1'b0, result.br_valid);
        $display("test gand done");
    endtask

    // mask branches, taken and not, both offset signs
    task automatic test_mask();
        logic [3:0] op [4] = '{4'h4, 4'h4, 4'h8, 4'h8};
        logic [31:0] sv [4] = '{32'hFFFF_00FF, 32'hFFFF_FF0F,
                                32'h0000_0001, 32'h7FFF_FFFE};
        logic [31:0] tv [4] = '{32'h0000_00F0, 32'h0000_00F0,
                                32'h8000_0001, 32'h8000_0001};
        logic [7:0] off [4] = '{8'h80, 8'h10, 8'h7F, 8'hF0};
        logic tk [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic [31:0] pc;
        pc = 32'h0000_2000;
        for (int i = 0; i < 4; i++) begin
            fetch_regfile_model_inst.regs[6] = sv[i];
            fetch_regfile_model_inst.regs[7] = tv[i];
            fetch_regfile_model_inst.offer({off[i], op[i], 8'h67, 4'h7}, pc);
            check_bit("br_valid", 1'b1, result.br_valid);
            check_bit("br_taken", tk[i], result.br_taken);
            check_word("next_pc", tk[i] ? pc + {{24{off[i][7]}}, off[i]}
                + 32'h4 : pc + 32'h3, result.next_pc);
            check_bit("gr_we", 1'b0, result.gr_we);
        end
        $display("test mask done");
    endtask

    // bit-clear branch with both bit numberings and dirty upper index bits
    task automatic test_bit_clear();
        logic [4:0] idx;
        logic tk;
        for (int i = 0; i < 4; i++) begin
            idx = i[1] ? 5'd31 : 5'd0;
            big_endian_flag = i[0];
            fetch_regfile_model_inst.regs[8] = 32'h0000_0001;
            fetch_regfile_model_inst.regs[9] = {27'h7FF_FFFF, idx};
            tk = ~fetch_regfile_model_inst.regs[8][idx ^ {5{i[0]}}];
            fetch_regfile_model_inst.offer(24'hF95897, 32'h0000_0400);
            check_bit("br_taken", tk, result.br_taken);
            check_word("next_pc", tk ? 32'h0000_03FD : 32'h0000_0403,
                result.next_pc);
        end
        big_endian_flag = 1'b0;
        $display("test bit_clear done");
    endtask

    // predicate ops with the feature on, then refused with it off
    task automatic test_pred();
        logic [23:0] w [6] = '{24'h009410, 24'h00B820, 24'h008C30,
                               24'h00A040, 24'h025670, 24'h126120};
        logic [15:0] e;
        e = PRED_RESET;
        for (int f = 1; f >= 0; f--) begin
            pred_feature_en = f[0];
            for (int i = 0; i < 6; i++) begin
                fetch_regfile_model_inst.offer(w[i], 32'h0000_0800);
                // expected file after each word, from the operation rules
                if (f[0]) begin
                    case (i)
                        0: e[1] = &e[7:4];
                        1: e[2] = &e[15:8];
                        2: e[3] = |e[15:12];
                        3: e[4] = |e[7:0];
                        4: e[5] = e[6] & e[7];
                        default: e[6] = e[1] & ~e[2];
                    endcase
                end
                check_bit("done", 1'b1, result.done);
                check_bit("illegal", ~f[0], result.illegal);
                check_word("pred_bits", {16'h0, e}, {16'h0, pred_bits});
                check_word("next_pc", 32'h0000_0803, result.next_pc);
            end
        end
        pred_feature_en = 1'b1;
        $display("test pred done");
    endtask

    // unknown opcode fields
    task automatic test_illegal();
        fetch_regfile_model_inst.offer(24'hFF1230, 32'h0000_1000);
        check_bit("illegal", 1'b1, result.illegal);
        check_bit("gr_we", 1'b0, result.gr_we);
        check_word("next_pc", 32'h0000_1003, result.next_pc);
        $display("test illegal done");
    endtask

    // watchdog, far beyond the fifty or so cycles the tests need
    initial begin
        #100000;
        err_total++;
        results();
    end

    // reset, reset values, then scenarios
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check_word("next_pc", 32'h0, result.next_pc);
        check_word("pred_bits", {16'h0, PRED_RESET}, {16'h0, pred_bits});
        test_gand();
        test_mask();
        test_bit_clear();
        test_pred();
        test_illegal();
        results();
    end
endmodule
`default_nettype wire
